// File: rtl/atb_consts.vh
// Purpose: constants for the area translation buffer
// Assumes: 32-bit entries, four match/translate pairs
// Notes: definitions only
`ifndef ATB_CONSTS_VH
`define ATB_CONSTS_VH
// register selects on the special-register port
`define ATB_SEL_MATCH 1'b0
`define ATB_SEL_XLAT 1'b1
// match entry fields
`define ATB_M_TAG_HI 31
`define ATB_M_TAG_LO 10
`define ATB_M_SIZE 5
`define ATB_M_CTX_HI 4
`define ATB_M_CTX_LO 1
`define ATB_M_VALID 0
// match entry reset value of the low control bits
`define ATB_M_CTRL_RST 6'h00
// area sizes as address bit counts (16 Mbyte, 32 Gbyte)
`define ATB_AREA_SMALL_BITS 24
`define ATB_AREA_LARGE_BITS 35
// translate entry fields
`define ATB_T_PFN_HI 31
`define ATB_T_PFN_LO 10
`define ATB_T_UW 9
`define ATB_T_UR 8
`define ATB_T_SW 7
`define ATB_T_SR 6
`define ATB_T_DIRTY 5
`define ATB_T_ACC 4
`define ATB_T_WOM 3
`define ATB_T_WBC 2
`define ATB_T_CI 1
`define ATB_T_CC 0
`endif

// File: rtl/atb_match.v
// Purpose: one match comparator for an area entry
// Assumes: 32-bit effective address, area masks from size select
// Notes: purely combinational
`timescale 1ns/1ps
`include "atb_consts.vh"
module atb_match (
  // stored match entry
  input wire [31:0] i_entry,
  // lookup request
  input wire [31:0] i_effective_address,
  input wire [3:0] i_current_context_field,
  // result
  output wire o_hit
);
  // mask of compared address bits: a 16 Mbyte area compares 31..24,
  // a 32 Gbyte area exceeds the 32-bit space so no address bit compares
  wire [31:0] small_mask;
  wire [31:0] cmp_mask;
  wire addr_eq;
  wire ctx_eq;
  assign small_mask = {32{1'b1}} << `ATB_AREA_SMALL_BITS;
  assign cmp_mask = i_entry[`ATB_M_SIZE] ? 32'h00000000 : small_mask;
  // tag field compared within the selected area size
  assign addr_eq = ((i_entry ^ i_effective_address) & cmp_mask &
                    32'hFFFFFC00) == 32'h00000000;
  assign ctx_eq = i_entry[`ATB_M_CTX_HI:`ATB_M_CTX_LO] ==
                  i_current_context_field;
  assign o_hit = i_entry[`ATB_M_VALID] & addr_eq & ctx_eq;
endmodule // atb_match

// File: rtl/atb_top.v
// Purpose: area translation buffer with match and translate pairs
// Assumes: core drives special-register moves and lookups on i_mclk
// Notes: lookup result is registered, one cycle after the request
`timescale 1ns/1ps
`include "atb_consts.vh"
module atb_top #(
  parameter ENTRIES = 4,
  parameter IDX_W = 2,
  parameter HAS_CONTEXT = 1
) (
  // clock, reset, enable
  input wire i_mclk,
  input wire i_reset,
  input wire i_ce,
  // special-register move port
  input wire i_spr_supervisor,
  input wire i_spr_write,
  input wire i_spr_read,
  input wire i_spr_sel,
  input wire [IDX_W-1:0] i_spr_index,
  input wire [31:0] i_spr_wdata,
  output reg [31:0] o_spr_rdata,
  output reg o_spr_denied,
  // lookup request from fetch or load/store
  input wire i_lookup,
  input wire i_store,
  input wire i_user_mode,
  input wire [31:0] i_effective_address,
  input wire [3:0] i_current_context_field,
  // lookup answer
  output reg o_area_hit,
  output reg o_access_fault,
  output reg [31:0] o_physical_address,
  output reg o_coherency_enforce,
  output reg o_cache_inhibit,
  output reg o_writeback_select,
  output reg o_weak_ordering_select
);
  // storage
  reg [31:0] area_match_entry [0:ENTRIES-1];
  reg [31:0] data_area_translate_entry [0:ENTRIES-1];
  // per-entry hit vector
  wire [ENTRIES-1:0] hit_vec;
  // effective context, zero when fast context switching is absent
  wire [3:0] ctx_in;
  // single-hit decode
  reg [IDX_W-1:0] hit_idx;
  reg [IDX_W:0] hit_cnt;
  reg [31:0] sel_t;
  reg [31:0] sel_m;
  reg [31:0] next_pa;
  reg allowed;
  wire one_hit;
  wire spr_ok;
  integer k;
  genvar g;

  assign ctx_in = HAS_CONTEXT ? i_current_context_field : 4'h0;
  assign spr_ok = i_spr_supervisor;

  // one comparator per entry
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_cmp
      atb_match u_match (
        .i_entry(area_match_entry[g]),
        .i_effective_address(i_effective_address),
        .i_current_context_field(ctx_in),
        .o_hit(hit_vec[g])
      );
    end
  endgenerate

  // count hits and pick the hitting entry
  always @* begin
    hit_idx = {IDX_W{1'b0}};
    hit_cnt = {(IDX_W+1){1'b0}};
    for (k = 0; k < ENTRIES; k = k + 1) begin
      if (hit_vec[k]) begin
        hit_idx = k[IDX_W-1:0];
        hit_cnt = hit_cnt + {{IDX_W{1'b0}}, 1'b1};
      end
    end
  end

  assign one_hit = (hit_cnt == {{IDX_W{1'b0}}, 1'b1});

  // form translated address and check permissions
  always @* begin
    sel_t = data_area_translate_entry[hit_idx];
    sel_m = area_match_entry[hit_idx];
    // keep offset bits inside the area, replace the page bits
    if (sel_m[`ATB_M_SIZE]) begin
      next_pa = i_effective_address; // whole space is the area
    end else begin
      next_pa = {sel_t[31:`ATB_AREA_SMALL_BITS],
                 i_effective_address[`ATB_AREA_SMALL_BITS-1:0]};
    end
    // pick the allow bit for mode and direction
    case ({i_user_mode, i_store})
      2'b11: allowed = sel_t[`ATB_T_UW];
      2'b10: allowed = sel_t[`ATB_T_UR];
      2'b01: allowed = sel_t[`ATB_T_SW];
      default: allowed = sel_t[`ATB_T_SR];
    endcase
  end

  // register file and accessed/dirty update
  always @(posedge i_mclk) begin
    if (i_reset) begin
      for (k = 0; k < ENTRIES; k = k + 1) begin
        // tag left as is; control bits cleared so all invalid
        area_match_entry[k][5:0] <= `ATB_M_CTRL_RST;
        // reserved bits 9..6 always read as zero, so clear them too
        area_match_entry[k][9:6] <= 4'h0;
      end
    end else if (i_ce) begin
      // hardware marks page accessed and, on store, modified
      if (i_lookup && one_hit && allowed) begin
        data_area_translate_entry[hit_idx][`ATB_T_ACC] <= 1'b1;
        if (i_store) begin
          data_area_translate_entry[hit_idx][`ATB_T_DIRTY] <= 1'b1;
        end
      end
      // software write after so a move overrides the marks
      if (i_spr_write && spr_ok) begin
        if (i_spr_sel == `ATB_SEL_MATCH) begin
          area_match_entry[i_spr_index] <= {i_spr_wdata[31:10], 4'h0,
            i_spr_wdata[5], HAS_CONTEXT ? i_spr_wdata[4:1] : 4'h0,
            i_spr_wdata[0]};
        end else begin
          data_area_translate_entry[i_spr_index] <= i_spr_wdata;
        end
      end
    end
  end

  // register read and denial flag
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_spr_rdata <= 32'h00000000;
      o_spr_denied <= 1'b0;
    end else if (i_ce) begin
      o_spr_denied <= (i_spr_read | i_spr_write) & ~spr_ok;
      if (i_spr_read && spr_ok) begin
        if (i_spr_sel == `ATB_SEL_MATCH) begin
          o_spr_rdata <= area_match_entry[i_spr_index];
        end else begin
          o_spr_rdata <= data_area_translate_entry[i_spr_index];
        end
      end else begin
        o_spr_rdata <= 32'h00000000; // no read: zero
      end
    end
  end

  // lookup answer, one cycle after request
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_area_hit <= 1'b0;
      o_access_fault <= 1'b0;
      o_physical_address <= 32'h00000000;
      o_coherency_enforce <= 1'b0;
      o_cache_inhibit <= 1'b0;
      o_writeback_select <= 1'b0;
      o_weak_ordering_select <= 1'b0;
    end else if (i_ce) begin
      o_area_hit <= i_lookup & one_hit;
      o_access_fault <= i_lookup & one_hit & ~allowed;
      if (i_lookup && one_hit) begin
        o_physical_address <= next_pa;
        o_coherency_enforce <= sel_t[`ATB_T_CC];
        o_cache_inhibit <= sel_t[`ATB_T_CI];
        o_writeback_select <= sel_t[`ATB_T_WBC];
        o_weak_ordering_select <= sel_t[`ATB_T_WOM];
      end else begin
        // pass-through address, attributes cleared
        o_physical_address <= i_effective_address;
        o_coherency_enforce <= 1'b0;
        o_cache_inhibit <= 1'b0;
        o_writeback_select <= 1'b0;
        o_weak_ordering_select <= 1'b0;
      end
    end
  end
endmodule // atb_top

// File: tb/atb_top_monitor.sv
// Purpose: port checker for the area translation buffer
// Assumes: one clock, sync active-high reset
// Notes: bound to atb_top below
`timescale 1ns/1ps
module atb_top_monitor (
  // clock, reset, requests, read data and physical address
  input logic i_mclk, i_reset, i_ce, i_spr_supervisor, i_spr_write,
  input logic i_spr_read, i_lookup,
  input logic [31:0] i_effective_address, o_spr_rdata, o_physical_address,
  // answers
  input logic o_spr_denied, o_area_hit, o_access_fault, o_coherency_enforce,
  input logic o_cache_inhibit, o_writeback_select, o_weak_ordering_select
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // a move outside supervisor mode is refused on the next cycle
  chk_deny_user: assert property (
    i_ce && (i_spr_write || i_spr_read) && !i_spr_supervisor |=> o_spr_denied)
    else $error("move outside supervisor not refused");
  // a supervisor move is never refused
  chk_super_ok: assert property (
    i_ce && (i_spr_write || i_spr_read) && i_spr_supervisor |=> !o_spr_denied)
    else $error("supervisor move refused");
  // without a hit no cache attribute leaks out
  chk_nohit_flags: assert property (
    !o_area_hit |-> !(o_coherency_enforce || o_cache_inhibit ||
    o_writeback_select || o_weak_ordering_select))
    else $error("attributes shown without hit");
  // a missed lookup passes the address through
  chk_nohit_addr: assert property (
    i_ce && i_lookup |=> o_area_hit ||
    o_physical_address == $past(i_effective_address))
    else $error("missed address altered");
  // offset bits below the smallest area are never replaced
  chk_offset_pass: assert property (
    i_ce && i_lookup |=>
    o_physical_address[23:0] == $past(i_effective_address[23:0]))
    else $error("area offset altered");
  // a permission fault only comes with a hit
  chk_fault_hit: assert property (
    o_access_fault |-> o_area_hit) else $error("fault without hit");
  // read data is zero in cycles without a read
  chk_idle_rdata: assert property (
    i_ce && !i_spr_read |=> o_spr_rdata == 32'h0)
    else $error("read data without read");
  // first cycle after reset shows cleared outputs
  chk_reset_clear: assert property (
    $fell(i_reset) |-> !o_area_hit && !o_spr_denied && o_spr_rdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule // atb_top_monitor

bind atb_top atb_top_monitor mon (.i_mclk, .i_reset, .i_ce,
  .i_spr_supervisor, .i_spr_write, .i_spr_read, .i_lookup,
  .i_effective_address, .o_spr_rdata, .o_physical_address, .o_spr_denied,
  .o_area_hit, .o_access_fault, .o_coherency_enforce, .o_cache_inhibit,
  .o_writeback_select, .o_weak_ordering_select);

// File: tb/atb_core_model.sv
// Purpose: core side making data lookups
// Assumes: requests change at the falling edge
// Notes: released address shows its inverse
`timescale 1ns/1ps
module atb_core_model (
  input logic i_mclk,
  output logic o_lookup, o_store, o_user_mode,
  output logic [31:0] o_effective_address,
  output logic [3:0] o_context
);
  initial begin
    o_lookup = 0;
    {o_store, o_user_mode, o_effective_address, o_context} = '0;
  end
  // one lookup held over one rising edge, then released
  task automatic req(input logic [31:0] a, input logic [3:0] c,
                     input logic u, s);
    @(negedge i_mclk);
    o_lookup = 1;
    {o_effective_address, o_context, o_user_mode, o_store} = {a, c, u, s};
    @(negedge i_mclk);
    o_lookup = 0;
    {o_effective_address, o_context} = {~a, ~c};
  endtask
endmodule // atb_core_model

// File: tb/atb_top_test.sv
// Purpose: directed test of the area translation buffer
// Assumes: four entries, context field in use
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module atb_top_test;
  logic clk = 0, rst = 1, ce = 1, sup = 1, we = 0, re = 0, sel = 0;
  logic [1:0] idx = 0;
  logic [31:0] wd = 0;
  wire [31:0] rdat, pa, ea;
  wire [3:0] ctx;
  wire den, hit, flt, cc, ci, wb, wo, lk, st, um;
  int failures = 0, tests_run = 0, i;
  always #12.5 clk = ~clk;
  atb_core_model core (.i_mclk(clk), .o_lookup(lk), .o_store(st),
    .o_user_mode(um), .o_effective_address(ea), .o_context(ctx));
  atb_top dut (.i_mclk(clk), .i_reset(rst), .i_ce(ce),
    .i_spr_supervisor(sup), .i_spr_write(we), .i_spr_read(re),
    .i_spr_sel(sel), .i_spr_index(idx), .i_spr_wdata(wd),
    .o_spr_rdata(rdat), .o_spr_denied(den), .i_lookup(lk), .i_store(st),
    .i_user_mode(um), .i_effective_address(ea),
    .i_current_context_field(ctx), .o_area_hit(hit), .o_access_fault(flt),
    .o_physical_address(pa), .o_coherency_enforce(cc),
    .o_cache_inhibit(ci), .o_writeback_select(wb),
    .o_weak_ordering_select(wo));
  // compare one value and count it
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one register move: write when w is high, else read
  task automatic mv(input logic w, s, input logic [1:0] x,
                    input logic [31:0] d);
    @(negedge clk);
    {we, re, sel, idx, wd} = {w, !w, s, x, d};
    @(negedge clk);
    {we, re, wd} = {2'b00, ~d};
  endtask
  // print the verdict and stop
  task automatic conclude;
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    mv(0, 0, 0, 0);
    chk("match_low", 0, rdat & 32'h3FF);
    sup = 0;
    mv(1, 0, 0, 32'h1);
    sup = 1;
    chk("denied", 1, den);
    core.req(32'h10, 0, 0, 0);
    chk("refused", 0, hit);
    mv(1, 0, 0, 32'h12000001);
    mv(1, 1, 0, 32'hAB0003C0);
    core.req(32'h12345678, 0, 0, 0);
    chk("hit", 1, hit);
    chk("phys", 32'hAB345678, pa);
    mv(0, 1, 0, 0);
    chk("accessed", 32'hAB0003D0, rdat);
    core.req(32'h12345678, 0, 0, 1);
    mv(0, 1, 0, 0);
    chk("dirty", 32'hAB0003F0, rdat);
    core.req(32'h13345678, 0, 0, 0);
    chk("tag_miss", 0, hit);
    mv(1, 0, 0, 32'h12000007);
    for (i = 2; i < 4; i++) begin
      core.req(32'h12000000, i[3:0], 0, 0);
      chk("context", i == 3, hit);
    end
    // each allow bit alone, then all but that bit
    for (i = 0; i < 8; i++) begin
      mv(1, 1, 0, 32'hAB000000 | (i[2] ? 32'h3C0 ^ (32'h40 << i[1:0])
                                       : 32'h40 << i[1:0]));
      core.req(32'h12000000, 4'h3, i[1], i[0]);
      chk("fault", i[2], flt);
    end
    for (i = 0; i < 4; i++) begin
      mv(1, 1, 0, 32'hAB0003C0 | (1 << i));
      core.req(32'h12000000, 4'h3, 0, 0);
      chk("attrs", 1 << i, {wo, wb, ci, cc});
    end
    mv(1, 0, 1, 32'h12000007);
    core.req(32'h12000000, 4'h3, 0, 0);
    chk("double", 0, hit);
    mv(1, 0, 0, 0);
    mv(1, 1, 1, 32'h3C0);
    mv(1, 0, 1, 32'h21);
    core.req(32'hFEDCBA98, 0, 0, 0);
    chk("large_hit", 1, hit);
    chk("large_pa", 32'hFEDCBA98, pa);
    // a move while the enable is low must not land
    ce = 0;
    mv(1, 0, 1, 0);
    ce = 1;
    core.req(32'h01234567, 0, 0, 0);
    chk("frozen", 1, hit);
    // reserved match bits read back as zero
    mv(1, 0, 2, 32'hFFFFFFFF);
    mv(0, 0, 2, 0);
    chk("reserved", 32'hFFFFFC3F, rdat);
    conclude();
  end
endmodule // atb_top_test
